// >>> rcd_dbg_host.sv
// Serial debug host model that issues the forced reset write
`timescale 1ns/1ps

module rcd_dbg_host (
	input  wire logic       clk,
	input  wire logic       go,
	output logic            dbg_sel,
	output logic            dbg_wr,
	output logic            dbg_rd,
	output logic      [7:0] dbg_wdata
);
	logic go_d;

	// Idle bus at time zero
	initial begin
		go_d = 1'b0;
		{dbg_sel, dbg_wr, dbg_rd} = 3'b000;
		dbg_wdata = 8'h5A;
	end

	// One memory write of the force bit per rising go, a read back when go drops
	always @(posedge clk) begin
		go_d <= go;
		dbg_sel <= go ^ go_d;
		dbg_wr <= go & ~go_d;
		dbg_rd <= ~go & go_d;
		dbg_wdata <= (go & ~go_d) ? 8'h01 : ~dbg_wdata; // Released data toggles
	end
endmodule : rcd_dbg_host

// >>> rcd_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps

module rcd_pin_sync
	import rcd_pkg::*;
#(
	parameter logic IDLE = 1'b1
) (
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic pin,
	output logic      level
);

	rcd_sync_s r;
	rcd_sync_s next_r;

	// Shift the pin in; the level moves only when stages two and three agree
	always_comb begin
		next_r    = r;
		next_r.s1 = pin;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		if (r.s2 == r.s3) begin
			next_r.level = r.s3;
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '{s1: IDLE, s2: IDLE, s3: IDLE, level: IDLE};
		end else begin
			r <= next_r;
		end
	end

	assign level = r.level;

endmodule : rcd_pin_sync

// >>> rcd_pkg.sv
// Types shared by the reset cause block
package rcd_pkg;

	typedef enum logic [1:0] {
		RCD_RUN  = 2'b01,
		RCD_HOLD = 2'b10
	} rcd_state_e;

	typedef struct packed {
		rcd_state_e state;
		logic [7:0] cause;
		logic       armed;
		logic [7:0] hold_cnt;
		logic       sys_reset;
		logic       wdog_clear;
		logic [7:0] cpu_rdata;
		logic [7:0] dbg_rdata;
	} rcd_core_s;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
	} rcd_sync_s;

endpackage : rcd_pkg

// >>> rcd_regs.svh
// Constants for the reset cause and debug forced reset block
`ifndef RCD_REGS_SVH
`define RCD_REGS_SVH

// Reset cause flag positions
`define RCD_BIT_POWER_ON    7
`define RCD_BIT_PIN         6
`define RCD_BIT_WATCHDOG    5
`define RCD_BIT_BAD_OPCODE  4
`define RCD_BIT_BAD_ADDRESS 3
`define RCD_BIT_LOW_VOLTAGE 1

// Reset values and read masks
`define RCD_CAUSE_POR_VALUE 8'h82
`define RCD_CAUSE_READ_MASK 8'hFA
`define RCD_DBG_READ_VALUE  8'h00

// Watchdog service keys
`define RCD_KEY_FIRST  8'h55
`define RCD_KEY_SECOND 8'hAA

// Debug forced reset register field
`define RCD_DBG_FORCE_BIT 0

// Timing: bus clock period and least reset hold time
`define RCD_CLK_PERIOD_NS 100
`define RCD_HOLD_MIN_NS   1600
`define RCD_HOLD_CYCLES   ((`RCD_HOLD_MIN_NS + `RCD_CLK_PERIOD_NS - 1) / `RCD_CLK_PERIOD_NS)

`endif

// >>> rcd_reset_cause.sv
// Reset cause recorder, watchdog write decoder and debug forced reset
`timescale 1ns/1ps
`include "rcd_regs.svh"

// Functional notes
// - An 8-bit read-only reset cause register reports the source of the latest reset.
// - A debug-forced reset leaves every reset cause flag cleared.
// - With watchdog enabled, writing any value but 0x55 or 0xAA causes watchdog reset.
// - Writing 0x55 then 0xAA clears the watchdog counter; flags stay unchanged.
// - Power-on reset sets power-on bit 7 and low-voltage bit 1, clears others.
// - Enabled low-voltage trip resets, sets bit 1, keeps the power-on flag.
// - Other resets set bits 6..3 of active sources, clear the rest.
// - External reset pin low sets flag bit 6.
// - Watchdog timeout reset sets bit 5; none occurs while watchdog is disabled.
// - Unimplemented opcode, or stop with stop_allow 0, resets and sets bit 4.
// - Enter-debug instruction with debug_mode_allow 0 counts as a bad opcode.
// - Access to an unimplemented address resets and sets bit 3.
// - CPU writes to the debug forced reset register are ignored.
// - Reads of the debug forced reset register return 0x00.
// - Writing 1 to the debug force bit via the debug port resets the device.
// - With watchdog enabled in window mode, any cause-address write in the first 75% resets the device.
module rcd_reset_cause
	import rcd_pkg::*;
#(
	parameter int HOLD_CYCLES = `RCD_HOLD_CYCLES
) (
	input  wire logic       clk,
	input  wire logic       rst_n,
	// CPU access to the reset cause and debug forced reset addresses
	input  wire logic       cpu_cause_sel,
	input  wire logic       cpu_dbg_sel,
	input  wire logic       cpu_wr,
	input  wire logic       cpu_rd,
	input  wire logic [7:0] cpu_wdata,
	output logic      [7:0] cpu_rdata,
	// Serial debug port access to the debug forced reset register
	input  wire logic       dbg_sel,
	input  wire logic       dbg_wr,
	input  wire logic       dbg_rd,
	input  wire logic [7:0] dbg_wdata,
	output logic      [7:0] dbg_rdata,
	// Reset sources
	input  wire logic       reset_pin_n,
	input  wire logic       supply_low,
	input  wire logic       low_voltage_reset_enable,
	input  wire logic       watchdog_enable,
	input  wire logic       watchdog_window_mode,
	input  wire logic       wdog_late_window,
	input  wire logic       wdog_timeout,
	input  wire logic       bad_opcode_fetch,
	input  wire logic       stop_attempt,
	input  wire logic       stop_allow,
	input  wire logic       enter_debug_attempt,
	input  wire logic       debug_mode_allow,
	input  wire logic       bad_address_access,
	// Results
	output logic            sys_reset,
	output logic            wdog_clear,
	output logic      [7:0] reset_cause_register
);

	rcd_core_s r;
	rcd_core_s next_r;

	logic pin_level;
	logic supply_low_level;

	// True for either watchdog service key
	function automatic logic rcd_is_key(input logic [7:0] d);
		rcd_is_key = (d == `RCD_KEY_FIRST) || (d == `RCD_KEY_SECOND);
	endfunction : rcd_is_key

	// Pin-level sources pass the synchroniser
	rcd_pin_sync #(
		.IDLE (1'b1)
	) u_pin_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (reset_pin_n),
		.level (pin_level)
	);

	rcd_pin_sync #(
		.IDLE (1'b0)
	) u_supply_sync (
		.clk   (clk),
		.rst_n (rst_n),
		.pin   (supply_low),
		.level (supply_low_level)
	);

	// Reset event decode
	logic cause_wr;
	logic bad_key;
	logic win_viol;
	logic ev_wdog;
	logic ev_op;
	logic ev_addr;
	logic ev_pin;
	logic ev_lv;
	logic ev_dbg;
	logic ev_other;

	assign cause_wr = cpu_wr && cpu_cause_sel;
	assign bad_key  = cause_wr && !rcd_is_key(cpu_wdata);
	assign win_viol = cause_wr && watchdog_window_mode && !wdog_late_window;
	assign ev_wdog  = watchdog_enable && (wdog_timeout || bad_key || win_viol);
	assign ev_op    = bad_opcode_fetch || (stop_attempt && !stop_allow)
	                  || (enter_debug_attempt && !debug_mode_allow);
	assign ev_addr  = bad_address_access;
	assign ev_pin   = !pin_level;
	assign ev_lv    = low_voltage_reset_enable && supply_low_level;
	assign ev_dbg   = dbg_sel && dbg_wr && dbg_wdata[`RCD_DBG_FORCE_BIT];
	assign ev_other = ev_pin || ev_wdog || ev_op || ev_addr;

	// Next-state logic: event capture, reset hold and watchdog service decode
	always_comb begin
		next_r            = r;
		next_r.wdog_clear = 1'b0;
		next_r.dbg_rdata  = `RCD_DBG_READ_VALUE;
		if (cpu_rd) begin
			// CPU reads of the debug register return zero
			next_r.cpu_rdata = cpu_cause_sel ? (r.cause & `RCD_CAUSE_READ_MASK) : `RCD_DBG_READ_VALUE;
		end
		case (r.state)
			RCD_RUN: begin
				if (ev_lv || ev_dbg || ev_other) begin
					next_r.state     = RCD_HOLD;
					next_r.sys_reset = 1'b1;
					next_r.hold_cnt  = 8'(HOLD_CYCLES - 1);
					next_r.armed     = 1'b0;
					if (ev_lv) begin
						// Low voltage keeps only the power-on flag
						next_r.cause                       = 8'h00;
						next_r.cause[`RCD_BIT_POWER_ON]    = r.cause[`RCD_BIT_POWER_ON];
						next_r.cause[`RCD_BIT_LOW_VOLTAGE] = 1'b1;
					end else if (ev_dbg) begin
						next_r.cause = 8'h00;
					end else begin
						// Record every source active at entry
						next_r.cause                       = 8'h00;
						next_r.cause[`RCD_BIT_PIN]         = ev_pin;
						next_r.cause[`RCD_BIT_WATCHDOG]    = ev_wdog;
						next_r.cause[`RCD_BIT_BAD_OPCODE]  = ev_op;
						next_r.cause[`RCD_BIT_BAD_ADDRESS] = ev_addr;
					end
				end else if (cause_wr) begin
					// Service keys: first arms, second clears the watchdog
					if (cpu_wdata == `RCD_KEY_FIRST) begin
						next_r.armed = 1'b1;
					end else if (cpu_wdata == `RCD_KEY_SECOND && r.armed) begin
						next_r.wdog_clear = 1'b1;
						next_r.armed      = 1'b0;
					end else begin
						next_r.armed = 1'b0;
					end
				end
			end
			RCD_HOLD: begin
				// Hold the least time, then until pin and supply recover
				if (r.hold_cnt != 8'h00) begin
					next_r.hold_cnt = r.hold_cnt - 8'h01;
				end else if (pin_level && !ev_lv) begin
					next_r.state     = RCD_RUN;
					next_r.sys_reset = 1'b0;
				end
			end
			default: begin
				next_r.state     = RCD_HOLD;
				next_r.sys_reset = 1'b1;
				next_r.hold_cnt  = 8'(HOLD_CYCLES - 1);
			end
		endcase
	end

	// State register; power-on values on rst_n
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r.state      <= RCD_RUN;
			r.cause      <= `RCD_CAUSE_POR_VALUE;
			r.armed      <= 1'b0;
			r.hold_cnt   <= 8'h00;
			r.sys_reset  <= 1'b0;
			r.wdog_clear <= 1'b0;
			r.cpu_rdata  <= 8'h00;
			r.dbg_rdata  <= 8'h00;
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state register
	assign sys_reset            = r.sys_reset;
	assign wdog_clear           = r.wdog_clear;
	assign cpu_rdata            = r.cpu_rdata;
	assign dbg_rdata            = r.dbg_rdata;
	assign reset_cause_register = r.cause & `RCD_CAUSE_READ_MASK;

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_unused_zero: assert property (reset_cause_register[2] == 1'b0 && reset_cause_register[0] == 1'b0)
		else $error("Unused cause bits not zero");

	a_debug_clears: assert property (r.state == RCD_RUN && ev_dbg && !ev_lv
		|=> sys_reset && reset_cause_register == 8'h00)
		else $error("Debug reset left a flag set");

	a_bad_write: assert property (r.state == RCD_RUN && !ev_lv && !ev_dbg && watchdog_enable && bad_key
		|=> sys_reset && reset_cause_register[`RCD_BIT_WATCHDOG])
		else $error("Bad key write did not reset");

	a_service_clear: assert property (r.state == RCD_RUN && cause_wr && cpu_wdata == `RCD_KEY_FIRST
		&& !ev_lv && !ev_dbg && !ev_other
		##1 r.state == RCD_RUN && cause_wr && cpu_wdata == `RCD_KEY_SECOND && !ev_lv && !ev_dbg && !ev_other
		|=> wdog_clear && !sys_reset && $stable(reset_cause_register))
		else $error("Service sequence did not clear watchdog");

	a_low_voltage: assert property (r.state == RCD_RUN && ev_lv
		|=> sys_reset && reset_cause_register[`RCD_BIT_LOW_VOLTAGE]
		&& reset_cause_register[`RCD_BIT_POWER_ON] == $past(r.cause[`RCD_BIT_POWER_ON]))
		else $error("Low voltage entry wrong");

	a_other_clear: assert property (r.state == RCD_RUN && ev_other && !ev_lv && !ev_dbg
		|=> !reset_cause_register[`RCD_BIT_POWER_ON] && !reset_cause_register[`RCD_BIT_LOW_VOLTAGE]
		&& reset_cause_register[`RCD_BIT_PIN] == $past(ev_pin))
		else $error("Other reset flags wrong");

	a_wdog_off: assert property (r.state == RCD_RUN && !watchdog_enable && !ev_lv && !ev_dbg
		&& !ev_pin && !ev_op && !ev_addr |=> !sys_reset)
		else $error("Watchdog reset while disabled");

	a_bad_opcode: assert property (r.state == RCD_RUN && !ev_lv && !ev_dbg
		&& enter_debug_attempt && !debug_mode_allow
		|=> sys_reset && reset_cause_register[`RCD_BIT_BAD_OPCODE])
		else $error("Disallowed debug entry not a bad opcode");

	a_bad_address: assert property (r.state == RCD_RUN && !ev_lv && !ev_dbg && bad_address_access
		|=> reset_cause_register[`RCD_BIT_BAD_ADDRESS])
		else $error("Bad address flag missing");

	a_user_ignored: assert property (r.state == RCD_RUN && cpu_wr && cpu_dbg_sel && !cpu_cause_sel
		&& !ev_lv && !ev_dbg && !ev_other |=> !sys_reset)
		else $error("CPU write forced a reset");

	a_dbg_zero: assert property (cpu_rd && cpu_dbg_sel && !cpu_cause_sel |=> cpu_rdata == 8'h00 && dbg_rdata == 8'h00)
		else $error("Debug register read not zero");

	a_reset_hold: assert property ($rose(sys_reset) |-> sys_reset [*8])
		else $error("Reset pulse too short");

	a_window_early: assert property (r.state == RCD_RUN && !ev_lv && !ev_dbg && watchdog_enable
		&& win_viol |=> sys_reset && reset_cause_register[`RCD_BIT_WATCHDOG])
		else $error("Early window write did not reset");

	// Every reset entry starts its hold with the full minimum count
	a_hold_load: assert property (
		$rose(sys_reset) |-> r.hold_cnt == 8'(HOLD_CYCLES - 1))
		else $error("Hold count not loaded at reset entry");

	// The hold counter steps down by one while the request stays high
	a_hold_count: assert property (
		r.state == RCD_HOLD && r.hold_cnt != 8'h00 |=> sys_reset && r.hold_cnt == $past(r.hold_cnt) - 8'h01)
		else $error("Hold counter did not step down");

	// A low reset pin keeps the device in reset
	a_hold_pin: assert property (
		r.state == RCD_HOLD && !pin_level |=> sys_reset)
		else $error("Reset released while pin low");

	// A supply below trip keeps the device in reset
	a_hold_supply: assert property (
		r.state == RCD_HOLD && ev_lv |=> sys_reset)
		else $error("Reset released while supply low");

	// Once the count is spent and the sources are gone, reset ends
	a_hold_release: assert property (
		r.state == RCD_HOLD && r.hold_cnt == 8'h00 && pin_level && !ev_lv |=> !sys_reset && r.state == RCD_RUN)
		else $error("Reset not released after hold");

	// Sources seen during the hold are not recorded
	a_hold_frozen: assert property (
		r.state == RCD_HOLD |=> $stable(reset_cause_register))
		else $error("Flags changed during hold");

	// Without any event the flags and the request stand still
	a_run_stable: assert property (
		r.state == RCD_RUN && !ev_lv && !ev_dbg && !ev_other |=> !sys_reset && $stable(reset_cause_register))
		else $error("Flags or request changed without an event");

	// A low-voltage reset clears the flags of the other sources
	a_lv_clears: assert property (
		r.state == RCD_RUN && ev_lv |=> (reset_cause_register & 8'h78) == 8'h00)
		else $error("Low voltage reset kept other flags");

	// Other resets record each active source and no inactive one
	a_other_bits: assert property (
		r.state == RCD_RUN && ev_other && !ev_lv && !ev_dbg
		|=> reset_cause_register[`RCD_BIT_WATCHDOG] == $past(ev_wdog)
		&& reset_cause_register[`RCD_BIT_BAD_OPCODE] == $past(ev_op)
		&& reset_cause_register[`RCD_BIT_BAD_ADDRESS] == $past(ev_addr))
		else $error("Source flags do not match active sources");

	// The second key alone does not service the watchdog
	a_second_alone: assert property (
		r.state == RCD_RUN && !r.armed && cause_wr && cpu_wdata == `RCD_KEY_SECOND |=> !wdog_clear)
		else $error("Second key without first key cleared watchdog");

	// The clear is a single-cycle pulse
	a_clear_pulse: assert property (
		wdog_clear |=> !wdog_clear)
		else $error("Watchdog clear longer than one cycle");

	// The first key arms the service sequence
	a_first_arms: assert property (
		r.state == RCD_RUN && cause_wr && cpu_wdata == `RCD_KEY_FIRST && !ev_lv && !ev_dbg && !ev_other |=> r.armed)
		else $error("First key did not arm");

	// Any other value breaks the service sequence
	a_bad_disarms: assert property (
		r.state == RCD_RUN && cause_wr && !rcd_is_key(cpu_wdata) |=> !r.armed)
		else $error("Non-key write left sequence armed");

	// A cause read returns the flags as they stood
	a_read_cause: assert property (
		cpu_rd && cpu_cause_sel |=> cpu_rdata == $past(reset_cause_register))
		else $error("Cause read data wrong");

	// A debug write with the force bit clear does not reset
	a_dbg_bit_zero: assert property (
		r.state == RCD_RUN && dbg_sel && dbg_wr && !dbg_wdata[`RCD_DBG_FORCE_BIT] && !ev_lv && !ev_other |=> !sys_reset)
		else $error("Debug write without force bit reset");

	// A low supply does not reset while its reset is disabled
	a_lv_disabled: assert property (
		r.state == RCD_RUN && !low_voltage_reset_enable && !ev_dbg && !ev_other |=> !sys_reset)
		else $error("Low voltage reset while disabled");

	// An enabled watchdog timeout resets with its flag
	a_wdog_timeout: assert property (
		r.state == RCD_RUN && watchdog_enable && wdog_timeout && !ev_lv && !ev_dbg
		|=> sys_reset && reset_cause_register[`RCD_BIT_WATCHDOG])
		else $error("Watchdog timeout did not reset");

	// A stop that is not allowed counts as a bad opcode
	a_stop_denied: assert property (
		r.state == RCD_RUN && stop_attempt && !stop_allow && !ev_lv && !ev_dbg
		|=> sys_reset && reset_cause_register[`RCD_BIT_BAD_OPCODE])
		else $error("Disallowed stop not a bad opcode");

endmodule : rcd_reset_cause

// >>> reset_cause_and_debug_reset_bench.sv
// Self-checking bench for the reset cause block
`timescale 1ns/1ps

module reset_cause_and_debug_reset_bench;
	logic       clk = 0, rst_n = 0, cs = 0, ds = 0, wr = 0, rd = 0, go = 0, rd_d = 0, seen = 0;
	logic       pin_n = 1, sup = 0, lvre = 0, wde = 0, wwin = 0, late = 0, sta = 0, dba = 0;
	logic [4:0] evt = 5'h00;
	logic [7:0] wd = 8'h00, k;
	logic       sys_reset, wdog_clear, dsel, dwr, drd;
	logic [7:0] rdata, drdata, cause, dwd;
	logic [7:0] qc[$], qr[$], qw[$];
	logic [7:0] expv [5] = '{8'h20, 8'h10, 8'h10, 8'h10, 8'h08};
	int         n_mismatch = 0, checks_done = 0, cyc = 0;

	always #50 clk = ~clk;

	rcd_reset_cause #(.HOLD_CYCLES(8)) dut_u (
		.clk(clk), .rst_n(rst_n), .cpu_cause_sel(cs), .cpu_dbg_sel(ds), .cpu_wr(wr), .cpu_rd(rd),
		.cpu_wdata(wd), .cpu_rdata(rdata), .dbg_sel(dsel), .dbg_wr(dwr), .dbg_rd(drd),
		.dbg_wdata(dwd), .dbg_rdata(drdata), .reset_pin_n(pin_n), .supply_low(sup),
		.low_voltage_reset_enable(lvre), .watchdog_enable(wde), .watchdog_window_mode(wwin),
		.wdog_late_window(late), .wdog_timeout(evt[0]), .bad_opcode_fetch(evt[1]),
		.stop_attempt(evt[2]), .stop_allow(sta), .enter_debug_attempt(evt[3]),
		.debug_mode_allow(dba), .bad_address_access(evt[4]), .sys_reset(sys_reset),
		.wdog_clear(wdog_clear), .reset_cause_register(cause)
	);

	rcd_dbg_host host_u (
		.clk(clk), .go(go), .dbg_sel(dsel), .dbg_wr(dwr), .dbg_rd(drd), .dbg_wdata(dwd)
	);

	task chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_byte

	task chk_flag(input string nm, input logic e, input logic g);
		checks_done++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %b seen %b", nm, e, g);
		end
	endtask : chk_flag

	task complete_run();
		$display("Comparisons %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : complete_run

	// One CPU access cycle, write when w is high, read otherwise
	task acc(input logic c, input logic d, input logic w, input logic [7:0] v);
		@(posedge clk);
		cs <= c;
		ds <= d;
		wr <= w;
		rd <= ~w;
		wd <= v;
		@(posedge clk);
		{cs, ds, wr, rd} <= 4'h0;
	endtask : acc

	task cr(input logic c, input logic d, input logic [7:0] e);
		qr.push_back(e);
		acc(c, d, 1'b0, 8'h00);
	endtask : cr

	// Wait for the reset request to reach a level
	task wt(input logic v);
		int n;
		n = 0;
		while (sys_reset !== v && n < 300) begin
			@(negedge clk);
			n++;
		end
		chk_flag("sys_reset level", v, sys_reset);
		@(posedge clk);
	endtask : wt

	// Expect one reset with the given cause, then release every source
	task hit(input logic [7:0] e);
		qc.push_back(e);
		wt(1'b1);
		evt <= 5'h00;
		sup <= 1'b0;
		pin_n <= 1'b1;
		go <= 1'b0;
		wt(1'b0);
		repeat (4) @(posedge clk);
	endtask : hit

	// Expect no reset for a while
	task quiet();
		@(posedge clk);
		evt <= 5'h00;
		repeat (20) @(posedge clk);
		chk_flag("sys_reset", 1'b0, sys_reset);
	endtask : quiet

	// Cycle ceiling and read strobe delay
	always @(posedge clk) begin
		rd_d <= rd;
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			n_mismatch++;
			complete_run();
		end
	end

	// Result watcher takes the oldest note for each result seen
	always @(negedge clk) begin
		if (sys_reset === 1'b1 && !seen) chk_byte("cause", qc.size() ? qc.pop_front() : 8'hXX, cause);
		seen = sys_reset;
		if (rd_d) chk_byte("cpu_rdata", qr.size() ? qr.pop_front() : 8'hXX, rdata);
		if (wdog_clear === 1'b1) chk_byte("wdog_clear", qw.size() ? qw.pop_front() : 8'hXX, 8'h01);
	end

	// Main sequence
	initial begin
		void'($urandom(46));
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		wde <= 1'b1;
		lvre <= 1'b1;
		repeat (4) @(posedge clk);
		cr(1'b1, 1'b0, 8'h82);
		cr(1'b0, 1'b1, 8'h00);
		qw.push_back(8'h01);
		acc(1'b1, 1'b0, 1'b1, 8'h55);
		acc(1'b1, 1'b0, 1'b1, 8'hAA);
		cr(1'b1, 1'b0, 8'h82);
		acc(1'b0, 1'b1, 1'b1, 8'h01);
		quiet();
		sup <= 1'b1;
		hit(8'h82);
		for (int i = 0; i < 5; i++) begin
			evt[i] <= 1'b1;
			hit(expv[i]);
		end
		pin_n <= 1'b0;
		hit(8'h40);
		sup <= 1'b1;
		hit(8'h02);
		go <= 1'b1;
		hit(8'h00);
		do k = 8'($urandom_range(255)); while (k == 8'h55 || k == 8'hAA);
		acc(1'b1, 1'b0, 1'b1, k);
		hit(8'h20);
		wde <= 1'b0;
		lvre <= 1'b0;
		sup <= 1'b1;
		evt[0] <= 1'b1;
		acc(1'b1, 1'b0, 1'b1, k);
		quiet();
		sta <= 1'b1;
		dba <= 1'b1;
		sup <= 1'b0;
		evt[3:2] <= 2'b11;
		quiet();
		wde <= 1'b1;
		wwin <= 1'b1;
		acc(1'b1, 1'b0, 1'b1, 8'h55);
		hit(8'h20);
		late <= 1'b1;
		qw.push_back(8'h01);
		acc(1'b1, 1'b0, 1'b1, 8'h55);
		acc(1'b1, 1'b0, 1'b1, 8'hAA);
		cr(1'b1, 1'b0, 8'h20);
		repeat (4) @(posedge clk);
		chk_byte("notes left", 8'h00, 8'(qc.size() + qr.size() + qw.size()));
		chk_byte("dbg_rdata", 8'h00, drdata);
		complete_run();
	end
endmodule : reset_cause_and_debug_reset_bench
